// file: verilog/prcr_cfg.svh
// Purpose: Offsets, field positions, reset values for the run-time control registers
// Assumes: 16-bit register words, SPI-style word access from the message layer
// Notes: Definitions only
`ifndef PRCR_CFG_SVH
`define PRCR_CFG_SVH

// ==========================================================================
// Register offsets
`define PRCR_RUN_CTRL_OFS 6'h06
`define PRCR_TOFF_CTRL_OFS 6'h07

// ==========================================================================
// Reset values
`define PRCR_RUN_CTRL_RST 16'h0001
`define PRCR_TOFF_CTRL_RST 16'h003d

// ==========================================================================
// Field positions
`define PRCR_CLR_SEC_BIT 6
`define PRCR_CLR_PRI_BIT 5
`define PRCR_CAPT_BIT 4
`define PRCR_TON_HI 3
`define PRCR_TON_LO 2
`define PRCR_TOFF_HI 5
`define PRCR_TOFF_LO 2
`define PRCR_LMI_BIT 1
`define PRCR_PAR_BIT 0

// ==========================================================================
// Encodings
`define PRCR_TON_HARD 2'h3
`define PRCR_TON_RST 2'h0
`define PRCR_TOFF_RST 4'hf

`endif

// file: verilog/prcr_pkg.sv
// Purpose: Types shared by the run-time control register bank
// Assumes: Nothing beyond the cfg header
// Notes: Types only
// ==========================================================================
package prcr_pkg;
    typedef logic [15:0] prcr_word_t;
    typedef enum logic [1:0] {
        PRCR_TON_WEAK = 2'h0,
        PRCR_TON_TWO_LEVEL = 2'h1
    } prcr_ton_mode_t;
endpackage : prcr_pkg

// file: verilog/prcr_parity.sv
// Purpose: Odd parity generation and check over a 16-bit word
// Assumes: Parity sits in bit 0 of the word
// Notes: Generated bit is registered; word check is combinational
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Odd parity unit
module prcr_parity
    import prcr_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Word to check
    input wire prcr_word_t i_word,
    // Registered result: the bit 0 value that gives odd parity over word bits 15:1
    output logic o_odd_bit,
    // Combinational: full word already has odd parity
    output logic o_word_ok
);
    logic odd_d;
    logic odd_q;

    // Bit 0 value that makes the total count odd
    assign odd_d = ~(^i_word[15:1]);
    assign o_word_ok = ^i_word;
    assign o_odd_bit = odd_q;

    // Register the generated bit
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            odd_q <= 1'b0;
        end else begin
            odd_q <= odd_d;
        end
    end
endmodule : prcr_parity

`default_nettype wire

// file: verilog/prcr_regs.sv
// Purpose: Primary-side run-time control registers (run control and turn-off control)
// Assumes: A message layer presents one decoded 16-bit word per pulse on i_msg_valid
// Notes: Read data is registered; request bits are one-cycle pulses that self-clear
//
// What this block does
// - Secondary clear bit 6 pulses, then self-clears
// - Primary clear bit 5 clears sticky, faults
// - Capture trigger bit 4 pulses, self-clears
// - Turn-on plateau codes 0-2 select levels
// - Code 3 hard switching in two-level mode
// - Turn-off plateau bits 5:2 select level
// - Bit 1 flags last message discarded
// - Bit 0 returns odd parity of word
// - Parity checked on reception when enabled
`timescale 1ns/1ps
`default_nettype none
`include "prcr_cfg.svh"

module prcr_regs
    import prcr_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Decoded serial message from the message layer
    input wire logic i_msg_valid,
    input wire logic i_msg_write,
    input wire logic [ADDR_W-1:0] i_msg_addr,
    input wire prcr_word_t i_msg_wdata,
    input wire logic i_msg_frame_err,
    // Configuration from other registers
    input wire logic i_odd_check_enable,
    input wire prcr_ton_mode_t i_ton_mode,
    // Read answer
    output logic o_rd_valid,
    output prcr_word_t o_rd_data,
    // Last message state
    output logic o_last_message_invalid,
    // Request pulses
    output logic o_clear_secondary_request,
    output logic o_clear_primary_request,
    output logic o_fault_release,
    output logic o_gate_timing_capture_trigger,
    // Plateau selections
    output logic [1:0] o_turn_on_plateau_level,
    output logic o_turn_on_hard_switching,
    output logic [3:0] o_turn_off_plateau_level
);
    // ======================================================================
    // Elaboration check
    if (ADDR_W < 4) begin : g_bad_addr_w
        $error("prcr_regs: ADDR_W must be at least 4");
    end

    // ======================================================================
    // Declarations
    // Stored fields and flag
    logic [1:0] ton_q;
    logic [1:0] ton_d;
    logic [3:0] toff_q;
    logic [3:0] toff_d;
    logic lmi_q;
    logic lmi_d;
    // Request pulses
    logic clr_sec_q;
    logic clr_sec_d;
    logic clr_pri_q;
    logic clr_pri_d;
    logic capt_q;
    logic capt_d;
    // Plateau and read answer
    logic hard_q;
    logic hard_d;
    logic [1:0] ton_out_q;
    logic rd_valid_q;
    prcr_word_t run_word;
    prcr_word_t toff_word;
    prcr_word_t rd_word_d;
    prcr_word_t rd_word_n;
    prcr_word_t rd_word_q;
    logic rd_odd;
    // Message decode
    logic word_ok;
    logic par_fail;
    logic hit_run;
    logic hit_toff;
    logic mapped;
    logic accept;
    logic wr_run;
    logic wr_toff;
    logic ton_reserved;

    // ======================================================================
    // Offset match, shared by both registers
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] ofs);
        reg_hit = (addr == ADDR_W'(ofs));
    endfunction : reg_hit

    // ======================================================================
    // Reception check and decode
    // Received word checked as a whole, parity bit included
    prcr_parity u_rx_parity (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_word (i_msg_wdata),
        .o_odd_bit (),
        .o_word_ok (word_ok)
    );

    // Only checked when enabled; disabled check never rejects
    assign par_fail = i_odd_check_enable & ~word_ok;
    assign hit_run = reg_hit(i_msg_addr, `PRCR_RUN_CTRL_OFS);
    assign hit_toff = reg_hit(i_msg_addr, `PRCR_TOFF_CTRL_OFS);
    assign mapped = hit_run | hit_toff;
    // Weak turn-on must not take code 3; such a write is discarded whole
    assign ton_reserved = (i_ton_mode == PRCR_TON_WEAK)
        & (i_msg_wdata[`PRCR_TON_HI:`PRCR_TON_LO] == `PRCR_TON_HARD);
    assign accept = i_msg_valid & ~i_msg_frame_err & ~par_fail & mapped
        & ~(i_msg_write & hit_run & ton_reserved);
    // Write strobes, only for messages that pass every check
    assign wr_run = accept & i_msg_write & hit_run;
    assign wr_toff = accept & i_msg_write & hit_toff;

    // ======================================================================
    // Next values: only writable fields taken, the rest ignored
    assign ton_d = wr_run ? i_msg_wdata[`PRCR_TON_HI:`PRCR_TON_LO] : ton_q;
    assign toff_d = wr_toff ? i_msg_wdata[`PRCR_TOFF_HI:`PRCR_TOFF_LO] : toff_q;
    // Flag updates on every message, so it describes the message being taken
    assign lmi_d = i_msg_valid ? ~accept : lmi_q;

    // ======================================================================
    // Request and plateau decode
    // Request bits are never stored, so they always read back as zero
    assign clr_sec_d = wr_run & i_msg_wdata[`PRCR_CLR_SEC_BIT];
    assign clr_pri_d = wr_run & i_msg_wdata[`PRCR_CLR_PRI_BIT];
    assign capt_d = wr_run & i_msg_wdata[`PRCR_CAPT_BIT];
    // Code 3 means hard switching only in two-level mode
    assign hard_d = (i_ton_mode == PRCR_TON_TWO_LEVEL) && (ton_d == `PRCR_TON_HARD);

    // ======================================================================
    // Read word selection
    // Built from the state being taken; unmapped offsets answer in run format
    assign run_word = {9'h000, 3'h0, ton_d, lmi_d, 1'b0};
    assign toff_word = {10'h000, toff_d, lmi_d, 1'b0};
    assign rd_word_d = hit_toff ? toff_word : run_word;
    // Answer stands until the next message, so idle cycles cannot disturb it
    assign rd_word_n = i_msg_valid ? rd_word_d : rd_word_q;

    // Parity over the word being returned, registered alongside it
    prcr_parity u_tx_parity (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_word (rd_word_n),
        .o_odd_bit (rd_odd),
        .o_word_ok ()
    );

    // ======================================================================
    // Stored fields and flags
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ton_q <= `PRCR_TON_RST;
            toff_q <= `PRCR_TOFF_RST;
            lmi_q <= 1'b0;
        end else begin
            ton_q <= ton_d;
            toff_q <= toff_d;
            lmi_q <= lmi_d;
        end
    end

    // ======================================================================
    // Self-clearing requests: high for one cycle after a write of one
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clr_sec_q <= 1'b0;
            clr_pri_q <= 1'b0;
            capt_q <= 1'b0;
        end else begin
            clr_sec_q <= clr_sec_d;
            clr_pri_q <= clr_pri_d;
            capt_q <= capt_d;
        end
    end

    // ======================================================================
    // Plateau outputs
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hard_q <= 1'b0;
            ton_out_q <= `PRCR_TON_RST;
        end else begin
            hard_q <= hard_d;
            ton_out_q <= ton_d;
        end
    end

    // ======================================================================
    // Read answer, one cycle after every message
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_valid_q <= 1'b0;
            rd_word_q <= 16'h0000;
        end else begin
            rd_valid_q <= i_msg_valid;
            rd_word_q <= rd_word_n;
        end
    end

    // ======================================================================
    // Outputs, all from flip-flops
    assign o_clear_secondary_request = clr_sec_q;
    assign o_clear_primary_request = clr_pri_q;
    assign o_fault_release = clr_pri_q;
    assign o_gate_timing_capture_trigger = capt_q;
    assign o_turn_on_plateau_level = ton_out_q;
    assign o_turn_on_hard_switching = hard_q;
    assign o_turn_off_plateau_level = toff_q;
    assign o_last_message_invalid = lmi_q;
    assign o_rd_valid = rd_valid_q;
    assign o_rd_data = {rd_word_q[15:1], rd_odd};
endmodule : prcr_regs

`default_nettype wire

// file: dv/prcr_regs_chk.sv
// Purpose: Assertions on the run-time control register bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to prcr_regs below
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker
module prcr_regs_chk
    import prcr_pkg::*;
(
    // Clock, reset and incoming message
    input wire logic i_ref_clk, i_reset_n, i_msg_valid, i_msg_write, i_odd_check_enable,
    input wire logic [5:0] i_msg_addr,
    input wire prcr_word_t i_msg_wdata,
    // Outputs watched
    input wire logic o_rd_valid, o_last_message_invalid, o_fault_release,
    input wire logic o_clear_secondary_request, o_clear_primary_request,
    input wire logic o_gate_timing_capture_trigger, o_turn_on_hard_switching,
    input wire prcr_word_t o_rd_data,
    input wire logic [1:0] o_turn_on_plateau_level,
    input wire logic [3:0] o_turn_off_plateau_level
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    // Write strobes per register
    logic wr_run;
    logic wr_off;
    assign wr_run = i_msg_valid && i_msg_write && i_msg_addr == 6'h06;
    assign wr_off = i_msg_valid && i_msg_write && i_msg_addr == 6'h07;
    a_answer_follows: assert property (i_msg_valid |=> o_rd_valid)
        else $error("no read answer");
    a_sec_clear_cause: assert property (o_clear_secondary_request |-> $past(wr_run && i_msg_wdata[6]))
        else $error("stray secondary clear");
    a_fault_release_pair: assert property ((o_fault_release || o_clear_primary_request) |->
        o_fault_release && o_clear_primary_request && $past(wr_run && i_msg_wdata[5]))
        else $error("fault release mismatch");
    a_capture_cause: assert property (o_gate_timing_capture_trigger |-> $past(wr_run && i_msg_wdata[4]))
        else $error("stray capture");
    a_on_level_hold: assert property (!$past(wr_run) |-> $stable(o_turn_on_plateau_level))
        else $error("turn-on level moved");
    a_off_level_hold: assert property (!$past(wr_off) |-> $stable(o_turn_off_plateau_level))
        else $error("turn-off level moved");
    a_flag_echo: assert property (o_rd_valid |-> o_rd_data[1] == o_last_message_invalid)
        else $error("flag not echoed");
    a_odd_word: assert property (o_rd_valid |-> ^o_rd_data)
        else $error("even parity");
    a_parity_reject: assert property (i_msg_valid && i_odd_check_enable && !(^i_msg_wdata) |=> o_last_message_invalid)
        else $error("bad parity accepted");
    a_reserved_zero: assert property (o_rd_valid |-> o_rd_data[15:7] == 9'h0)
        else $error("reserved bits set");
    c_sec_clear: cover property (o_clear_secondary_request);
    c_hard: cover property (o_turn_on_hard_switching);
    c_invalid: cover property (o_last_message_invalid);
endmodule : prcr_regs_chk
bind prcr_regs prcr_regs_chk u_chk (.i_ref_clk, .i_reset_n, .i_msg_valid, .i_msg_write,
    .i_odd_check_enable, .i_msg_addr, .i_msg_wdata, .o_rd_valid, .o_last_message_invalid,
    .o_fault_release, .o_clear_secondary_request, .o_clear_primary_request,
    .o_gate_timing_capture_trigger, .o_turn_on_hard_switching, .o_rd_data,
    .o_turn_on_plateau_level, .o_turn_off_plateau_level);
`default_nettype wire

// file: dv/prcr_host_model.sv
// Purpose: Serial master model delivering decoded messages
// Assumes: One message per call, driven just after a rising edge
// Notes: Idle lines toggle so a stale word is never mistaken for data
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host model
module prcr_host_model (
    // Clock
    input wire logic i_ref_clk,
    // Decoded message
    output logic o_msg_valid, o_msg_write, o_msg_frame_err,
    output logic [5:0] o_msg_addr,
    output logic [15:0] o_msg_wdata
);
    // Idle start with clean framing
    initial begin
        o_msg_valid = 1'b0;
        o_msg_write = 1'b0;
        o_msg_frame_err = 1'b0;
        o_msg_addr = 6'h3f;
        o_msg_wdata = 16'h5a5a;
    end
    // Set by the bench to mark the following messages as badly framed
    logic frame_bad = 1'b0;
    // One message; bit 0 makes the word odd unless spoilt on purpose
    task automatic send(input logic w, input logic [5:0] a, input logic [15:0] d, input logic bad);
        @(posedge i_ref_clk);
        #1;
        o_msg_valid = 1'b1;
        o_msg_frame_err = frame_bad;
        o_msg_write = w;
        o_msg_addr = a;
        o_msg_wdata = {d[15:1], ~^d[15:1] ^ bad};
        @(posedge i_ref_clk);
        #1;
        o_msg_valid = 1'b0;
        o_msg_frame_err = 1'b0;
        o_msg_write = ~w;
        o_msg_addr = ~a;
        o_msg_wdata = ~o_msg_wdata;
    endtask : send
endmodule : prcr_host_model
`default_nettype wire

// file: dv/prcr_regs_tb_top.sv
// Purpose: Self-checking bench for the run-time control registers
// Assumes: Host model drives messages, bench drives mode levels
// Notes: Frame errors come from the host model's frame_bad switch
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench
module prcr_regs_tb_top
    import prcr_pkg::*;
;
    logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_odd_check_enable = 1'b0;
    prcr_ton_mode_t i_ton_mode = PRCR_TON_WEAK;
    logic v, w, fe, rv, last_message_invalid, cs, cp, fr, gt, hs;
    logic [5:0] a;
    prcr_word_t d, rd;
    logic [1:0] ton;
    logic [3:0] toff;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    // Clock
    always #5 i_ref_clk = ~i_ref_clk;
    prcr_host_model host (.i_ref_clk, .o_msg_valid(v), .o_msg_write(w),
        .o_msg_frame_err(fe), .o_msg_addr(a), .o_msg_wdata(d));
    prcr_regs dut (.i_ref_clk, .i_reset_n, .i_msg_valid(v), .i_msg_write(w), .i_msg_addr(a),
        .i_msg_wdata(d), .i_msg_frame_err(fe), .i_odd_check_enable, .i_ton_mode,
        .o_rd_valid(rv), .o_rd_data(rd), .o_last_message_invalid(last_message_invalid),
        .o_clear_secondary_request(cs), .o_clear_primary_request(cp), .o_fault_release(fr),
        .o_gate_timing_capture_trigger(gt), .o_turn_on_plateau_level(ton),
        .o_turn_on_hard_switching(hs), .o_turn_off_plateau_level(toff));
    task automatic final_report();
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Answer word: field bits, flag, then odd parity over the rest
    function automatic prcr_word_t word(input logic [15:0] f, input logic l);
        word = {f[15:2], l, ~^{f[15:2], l}};
    endfunction : word
    // One message, then answer, flag and word in the answer cycle
    task automatic acc(input logic wr, input logic [5:0] ad, input logic [15:0] dt,
        input logic bad, input logic [15:0] f, input logic l);
        host.send(wr, ad, dt, bad);
        chk({rv, last_message_invalid, rd}, {1'b1, l, word(f, l)});
    endtask : acc
    // Hang guard, far above the roughly 75 cycles needed
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge i_ref_clk);
        #1 i_reset_n = 1'b1;
        chk(18'({ton, toff}), 18'h0f);
        acc(1'b0, 6'h07, 16'h0, 1'b0, 16'h003c, 1'b0);
        acc(1'b0, 6'h06, 16'h0, 1'b0, 16'h0000, 1'b0);
        acc(1'b1, 6'h06, 16'hfffa, 1'b0, 16'h0008, 1'b0);
        chk(18'({cs, cp, fr, gt, ton}), 18'h3e);
        @(posedge i_ref_clk);
        #1 chk(18'({cs, cp, fr, gt}), 18'h0);
        for (int c = 0; c < 16; c++) begin
            acc(1'b1, 6'h07, 16'(c << 2), 1'b0, 16'(c << 2), 1'b0);
            chk(18'(toff), 18'(c));
        end
        i_ton_mode = PRCR_TON_TWO_LEVEL;
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, 6'h06, 16'(c << 2), 1'b0, 16'(c << 2), 1'b0);
            chk(18'({hs, ton}), 18'({c == 3, 2'(c)}));
        end
        i_ton_mode = PRCR_TON_WEAK;
        acc(1'b1, 6'h06, 16'h0004, 1'b0, 16'h0004, 1'b0);
        acc(1'b1, 6'h06, 16'h000c, 1'b0, 16'h0004, 1'b1);
        i_odd_check_enable = 1'b1;
        acc(1'b1, 6'h07, 16'h0014, 1'b1, 16'h003c, 1'b1);
        acc(1'b0, 6'h07, 16'h0, 1'b0, 16'h003c, 1'b0);
        i_odd_check_enable = 1'b0;
        acc(1'b1, 6'h07, 16'h0014, 1'b1, 16'h0014, 1'b0);
        host.frame_bad = 1'b1;
        acc(1'b1, 6'h07, 16'h0008, 1'b0, 16'h0014, 1'b1);
        host.frame_bad = 1'b0;
        chk(18'(toff), 18'h5);
        acc(1'b0, 6'h08, 16'h0, 1'b0, 16'h0004, 1'b1);
        final_report();
    end
endmodule : prcr_regs_tb_top
`default_nettype wire
